// ==== afd_serial_ports.sv ====
// Audio decoder control port, stream port, input buffer and APB registers
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module afd_serial_ports
    import afd_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control port
    input wire logic ctl_select_n,
    input wire logic ctl_sclk,
    input wire logic ctl_sdi,
    output logic ctl_sdo,
    output logic ctl_sdo_oe,
    // Stream port
    input wire logic stream_clock_in,
    output logic stream_clock_out,
    output logic stream_clock_oe,
    input wire logic stream_data_in,
    input wire logic byte_sync,
    output logic data_request,
    // Decoder side byte output
    output logic [7:0] dec_byte_data,
    output logic dec_byte_valid,
    input wire logic dec_byte_take
);
    localparam int PW = $clog2(FIFO_DEPTH);

    // Synchronisers
    logic sel_m_r, sel_s_r, sck_m_r, sck_s_r, sck_d_r, sdi_m_r, sdi_s_r;
    logic sck_m2_r, scl_s_r, sda_m_r, sda_s_r, syn_m_r, syn_s_r;
    logic sck_rise, sck_fall;

    // Register file and control port
    logic [15:0] regs_r [REG_COUNT];
    afd_cp_state_e cp_state_r;
    logic [3:0] cp_bits_r;
    logic [15:0] cp_shift_r;
    logic [15:0] cp_shift_nxt;
    logic cp_read_r;
    logic [7:0] cp_addr_r;
    logic [15:0] cp_out_r;
    logic cp_wr_r;

    // Mode fields
    logic mode_falling, mode_lsb, mode_master, mode_fast;

    // Stream and buffer
    logic [7:0] div_cnt_r;
    logic [7:0] div_lim;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_r, rd_ptr_r;
    logic [PW:0] count_r;
    logic push, pop;
    logic [PW:0] free_cnt;
    logic room_ok;

    // APB
    logic [4:0] apb_idx;
    logic apb_status;
    logic apb_map;

    assign mode_falling = regs_r[MODE_IDX][MODE_EDGE_BIT];
    assign mode_lsb = regs_r[MODE_IDX][MODE_ORDER_BIT];
    assign mode_master = regs_r[MODE_IDX][MODE_MASTER_BIT];
    assign mode_fast = regs_r[MODE_IDX][MODE_RATE_BIT];

    // Pin synchronisers, two flops each
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_m_r <= 1'b1;
            sel_s_r <= 1'b1;
            sck_m_r <= 1'b0;
            sck_s_r <= 1'b0;
            sck_d_r <= 1'b0;
            sdi_m_r <= 1'b0;
            sdi_s_r <= 1'b0;
            sck_m2_r <= 1'b0;
            scl_s_r <= 1'b0;
            sda_m_r <= 1'b0;
            sda_s_r <= 1'b0;
            syn_m_r <= 1'b0;
            syn_s_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_m_r <= ctl_select_n;
            sel_s_r <= sel_m_r;
            sck_m_r <= ctl_sclk;
            sck_s_r <= sck_m_r;
            sck_d_r <= sck_s_r;
            sdi_m_r <= ctl_sdi;
            sdi_s_r <= sdi_m_r;
            // Own clock rides the same delay so data and edge stay aligned
            sck_m2_r <= mode_master ? stream_clock_out : stream_clock_in;
            scl_s_r <= sck_m2_r;
            sda_m_r <= stream_data_in;
            sda_s_r <= sda_m_r;
            syn_m_r <= byte_sync;
            syn_s_r <= syn_m_r;
        end
    end

    // Serial clock edges step the register interface; it caps the serial rate
    assign sck_rise = sck_s_r & ~sck_d_r & ~sel_s_r;
    assign sck_fall = ~sck_s_r & sck_d_r & ~sel_s_r;
    assign cp_shift_nxt = {cp_shift_r[14:0], sdi_s_r};

    // Control port sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cp_state_r <= CP_IDLE;
            cp_bits_r <= 4'h0;
            cp_shift_r <= 16'h0000;
            cp_read_r <= 1'b0;
            cp_addr_r <= 8'h00;
            cp_out_r <= 16'h0000;
            cp_wr_r <= 1'b0;
        end
        else if (clk_en)
        begin
            cp_wr_r <= 1'b0;
            if (sel_s_r)
            begin
                cp_state_r <= CP_IDLE;
                cp_bits_r <= 4'h0;
            end
            else
            begin
                case (cp_state_r)
                    CP_IDLE:
                    begin
                        cp_state_r <= CP_OPCODE;
                        cp_bits_r <= 4'h0;
                    end
                    CP_OPCODE:
                    begin
                        if (sck_rise)
                        begin
                            cp_shift_r <= cp_shift_nxt;
                            cp_bits_r <= cp_bits_r + 4'h1;
                            if (cp_bits_r == 4'h7)
                            begin
                                cp_bits_r <= 4'h0;
                                cp_read_r <= cp_shift_nxt[7:0] == OPC_READ;
                                if (cp_shift_nxt[7:0] == OPC_READ || cp_shift_nxt[7:0] == OPC_WRITE)
                                begin
                                    cp_state_r <= CP_ADDR;
                                end
                                else
                                begin
                                    cp_state_r <= CP_IGNORE;
                                end
                            end
                        end
                    end
                    CP_ADDR:
                    begin
                        if (sck_rise)
                        begin
                            cp_shift_r <= cp_shift_nxt;
                            cp_bits_r <= cp_bits_r + 4'h1;
                            if (cp_bits_r == 4'h7)
                            begin
                                cp_bits_r <= 4'h0;
                                cp_addr_r <= cp_shift_nxt[7:0];
                                cp_out_r <= reg_word(cp_shift_nxt[7:0]);
                                cp_state_r <= cp_read_r ? CP_RDATA : CP_WDATA;
                            end
                        end
                    end
                    CP_WDATA:
                    begin
                        if (sck_rise)
                        begin
                            cp_shift_r <= cp_shift_nxt;
                            cp_bits_r <= cp_bits_r + 4'h1;
                            if (cp_bits_r == 4'hF)
                            begin
                                cp_wr_r <= 1'b1;
                                cp_state_r <= CP_IGNORE;
                            end
                        end
                    end
                    CP_RDATA:
                    begin
                        // Input is ignored here; only falling edges matter
                        if (sck_fall)
                        begin
                            cp_out_r <= {cp_out_r[14:0], 1'b0};
                            cp_bits_r <= cp_bits_r + 4'h1;
                            if (cp_bits_r == 4'hF)
                            begin
                                cp_addr_r <= cp_addr_r + 8'h01;
                                cp_out_r <= reg_word(cp_addr_r + 8'h01);
                            end
                        end
                    end
                    CP_IGNORE:
                    begin
                        cp_state_r <= CP_IGNORE;
                    end
                    default:
                    begin
                        cp_state_r <= CP_IDLE;
                    end
                endcase
            end
        end
    end

    // Serial output driver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_sdo <= 1'b0;
            ctl_sdo_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            ctl_sdo_oe <= !sel_s_r && cp_state_r == CP_RDATA && !(cp_bits_r == 4'h0 && !ctl_sdo_oe && !sck_fall);
            if (sck_fall && cp_state_r == CP_RDATA)
            begin
                ctl_sdo <= cp_out_r[15];
            end
        end
    end

    function automatic logic [15:0] reg_word(input logic [7:0] a);
        if (a < 8'(REG_COUNT))
        begin
            return regs_r[a[REG_IDX_W-1:0]];
        end
        return 16'h0000;
    endfunction

    // APB slave: one wait state, answer on the second access cycle
    assign apb_idx = apb_index(paddr);
    assign apb_status = paddr == APB_STATUS_OFFSET;
    assign apb_map = apb_status || apb_idx < 5'(REG_COUNT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !apb_map;
            if (psel && penable && !pready)
            begin
                if (apb_status)
                begin
                    prdata <= 32'({count_r, mode_master, (cp_state_r != CP_IDLE), data_request});
                end
                else if (apb_idx < 5'(REG_COUNT))
                begin
                    prdata <= {16'h0000, regs_r[apb_idx[REG_IDX_W-1:0]]};
                end
                else
                begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Register file; a control-port write wins a same-cycle clash
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                regs_r[i] <= REG_RESET;
            end
        end
        else if (clk_en)
        begin
            if (cp_wr_r)
            begin
                if (cp_addr_r < 8'(REG_COUNT))
                begin
                    regs_r[cp_addr_r[REG_IDX_W-1:0]] <= cp_shift_r;
                end
            end
            else if (psel && penable && pready && pwrite && apb_idx < 5'(REG_COUNT))
            begin
                regs_r[apb_idx[REG_IDX_W-1:0]] <= pwdata[15:0];
            end
        end
    end

    // Master stream clock; paused while the buffer lacks room
    assign div_lim = mode_fast ? HALF_HI_LIM : HALF_LO_LIM;
    assign room_ok = free_cnt >= (PW+1)'(DATA_REQUEST_ROOM);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= 8'h00;
            stream_clock_out <= 1'b0;
            stream_clock_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            stream_clock_oe <= mode_master;
            if (!mode_master || (!stream_clock_out && !room_ok))
            begin
                div_cnt_r <= 8'h00;
            end
            else if (div_cnt_r >= div_lim)
            begin
                div_cnt_r <= 8'h00;
                stream_clock_out <= ~stream_clock_out;
            end
            else
            begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
            if (!mode_master)
            begin
                stream_clock_out <= 1'b0;
            end
        end
    end

    afd_stream_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .clk_lvl(scl_s_r),
        .data_lvl(sda_s_r),
        .sync_lvl(syn_s_r),
        .edge_falling(mode_falling),
        .lsb_first(mode_lsb),
        .byte_data(rx_byte),
        .byte_valid(rx_valid)
    );

    // Input buffer; bytes beyond full are lost, which flow control prevents
    assign push = rx_valid && count_r < (PW+1)'(FIFO_DEPTH);
    assign pop = count_r != '0 && (!dec_byte_valid || dec_byte_take);
    assign free_cnt = (PW+1)'(FIFO_DEPTH) - count_r;

    always_ff @(posedge pclk)
    begin
        if (clk_en && push)
        begin
            fifo_mem[wr_ptr_r] <= rx_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            dec_byte_data <= 8'h00;
            dec_byte_valid <= 1'b0;
            data_request <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_ptr_r <= push ? PW'((wr_ptr_r + 1'b1) % FIFO_DEPTH) : wr_ptr_r;
            rd_ptr_r <= pop ? PW'((rd_ptr_r + 1'b1) % FIFO_DEPTH) : rd_ptr_r;
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
            if (pop)
            begin
                dec_byte_data <= fifo_mem[rd_ptr_r];
                dec_byte_valid <= 1'b1;
            end
            else if (dec_byte_take)
            begin
                dec_byte_valid <= 1'b0;
            end
            data_request <= !mode_master && room_ok;
        end
    end

    a_sdo_standby: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && sel_s_r |=> !ctl_sdo_oe) else $error("serial output driven while deselected");
    a_write_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && cp_state_r == CP_WDATA |=> !ctl_sdo_oe) else $error("serial output driven during write");
    a_sdo_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(ctl_sdo) |-> $past(sck_fall)) else $error("serial output moved off a falling edge");
    a_shift_selected: assert property (@(posedge pclk) disable iff (!presetn)
        cp_state_r == CP_OPCODE && $changed(cp_shift_r) |-> $past(sck_rise) && !$past(sel_s_r))
        else $error("input sampled without edge or select");
    a_read_opcode: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cp_state_r) == CP_ADDR && cp_state_r == CP_RDATA |-> cp_read_r)
        else $error("read data phase without read opcode");
    a_write_commit: assert property (@(posedge pclk) disable iff (!presetn)
        cp_wr_r |-> $past(cp_state_r) == CP_WDATA && $past(cp_bits_r) == 4'hF)
        else $error("register write outside a full data word");
    a_read_next: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && cp_state_r == CP_RDATA && sck_fall && cp_bits_r == 4'hF && !sel_s_r
        |=> cp_addr_r == $past(cp_addr_r) + 8'h01) else $error("read address not advanced");
    a_data_request_room: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && free_cnt < (PW+1)'(DATA_REQUEST_ROOM) |=> !data_request) else $error("data request high without room");
    a_clock_period: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && mode_master && $changed(stream_clock_out) && $past(mode_master) |-> $past(div_cnt_r) >= $past(div_lim))
        else $error("master stream clock toggled early");
endmodule
`default_nettype wire

// ==== afd_pkg.sv ====
// Constants and types shared by the audio decoder serial port block
`default_nettype none
package afd_pkg;
    // Control-port register file
    localparam int REG_COUNT = 16;
    localparam int REG_IDX_W = 4;
    localparam int MODE_IDX = 0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Mode register fields
    localparam int MODE_EDGE_BIT = 8;
    localparam int MODE_ORDER_BIT = 9;
    localparam int MODE_MASTER_BIT = 10;
    localparam int MODE_RATE_BIT = 11;
    // Control-port opcodes
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    // APB map: register index times four, plus a status word
    localparam logic [11:0] APB_STATUS_OFFSET = 12'h0040;
    localparam logic [1:0] STS_DATA_REQUEST_BIT = 2'h0;
    // Timing
    localparam int PCLK_KHZ = 50000;
    localparam int STREAM_LO_KHZ = 512;
    localparam int STREAM_HI_KHZ = 1024;
    localparam int HALF_LO_CYC = PCLK_KHZ / (2 * STREAM_LO_KHZ);
    localparam int HALF_HI_CYC = PCLK_KHZ / (2 * STREAM_HI_KHZ);
    localparam logic [7:0] HALF_LO_LIM = 8'(HALF_LO_CYC - 1);
    localparam logic [7:0] HALF_HI_LIM = 8'(HALF_HI_CYC - 1);
    // Flow control room in bytes
    localparam int DATA_REQUEST_ROOM = 32;
    localparam int FIFO_DEPTH_DEF = 64;

    typedef enum logic [2:0] {
        CP_IDLE = 3'h0,
        CP_OPCODE = 3'h1,
        CP_ADDR = 3'h3,
        CP_WDATA = 3'h2,
        CP_RDATA = 3'h7,
        CP_IGNORE = 3'h6
    } afd_cp_state_e;

    // Register index of an APB byte address, or REG_COUNT when unmapped
    function automatic logic [4:0] apb_index(input logic [11:0] addr);
        if (addr[1:0] == 2'h0 && addr[11:2] < 10'(REG_COUNT))
        begin
            return 5'(addr[11:2]);
        end
        return 5'(REG_COUNT);
    endfunction
endpackage
`default_nettype wire

// ==== afd_stream_rx.sv ====
// Stream port bit assembler: edge pick, byte sync and bit order
`timescale 1ns/10ps
`default_nettype none
module afd_stream_rx
    import afd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Synchronised stream levels
    input wire logic clk_lvl,
    input wire logic data_lvl,
    input wire logic sync_lvl,
    // Configuration
    input wire logic edge_falling,
    input wire logic lsb_first,
    // Assembled bytes
    output logic [7:0] byte_data,
    output logic byte_valid
);
    logic clk_d_r;
    logic sync_prev_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic sample;
    logic restart;

    assign sample = edge_falling ? (clk_d_r & ~clk_lvl) : (~clk_d_r & clk_lvl);
    // Only a fresh sync pulse realigns; a tied-high sync never slips bytes
    assign restart = sync_lvl & ~sync_prev_r;
    assign shift_nxt = lsb_first ? {data_lvl, shift_r[7:1]} : {shift_r[6:0], data_lvl};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_d_r <= 1'b0;
        end
        else if (clk_en)
        begin
            clk_d_r <= clk_lvl;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_prev_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            byte_data <= 8'h00;
            byte_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            byte_valid <= 1'b0;
            if (sample)
            begin
                sync_prev_r <= sync_lvl;
                shift_r <= shift_nxt;
                // No boundary search: counting, restarted by a fresh sync pulse, frames bytes
                bit_cnt_r <= restart ? 3'h1 : bit_cnt_r + 3'h1;
                if (!restart && bit_cnt_r == 3'h7)
                begin
                    byte_data <= shift_nxt;
                    byte_valid <= 1'b1;
                end
            end
        end
    end

    a_sync_restart: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && sample && restart |=> bit_cnt_r == 3'h1) else $error("byte sync did not restart count");
    a_byte_on_eighth: assert property (@(posedge pclk) disable iff (!presetn)
        byte_valid |-> $past(bit_cnt_r) == 3'h7) else $error("byte emitted off the eighth bit");
endmodule
`default_nettype wire

// ==== afd_host_model.sv ====
// Host model driving the control port and the stream port
`timescale 1ns/10ps
`default_nettype none
module afd_host_model
(
    // Clock
    input wire logic pclk,
    // Control port
    output logic ctl_select_n,
    output logic ctl_sclk,
    output logic ctl_sdi,
    input wire logic ctl_sdo,
    // Stream port
    output logic stream_clock_in,
    output logic stream_data_in,
    output logic byte_sync
);
    initial
    begin
        ctl_select_n = 1'b1;
        ctl_sclk = 1'b0;
        ctl_sdi = 1'b0;
        stream_clock_in = 1'b0;
        stream_data_in = 1'b0;
        byte_sync = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Gated clock, eight pclk per phase keeps the pin synchronisers happy
    task automatic cp(input logic [31:0] w, output logic [15:0] rd);
        rd = 16'h0000;
        ctl_select_n <= 1'b0;
        tick(8);
        for (int i = 31; i >= 0; i--)
        begin
            ctl_sdi <= w[i];
            tick(8);
            ctl_sclk <= 1'b1;
            tick(8);
            rd = {rd[14:0], ctl_sdo};
            ctl_sclk <= 1'b0;
        end
        ctl_sdi <= ~ctl_sdi;
        tick(8);
        ctl_select_n <= 1'b1;
        tick(260);
    endtask
    // Falling mode moves data mid high phase, so a rising sampler slips a bit
    task automatic st(input logic [7:0] b, input logic lsb, input logic fall);
        for (int i = 0; i < 8; i++)
        begin
            if (!fall)
            begin
                stream_data_in <= lsb ? b[i] : b[7 - i];
                byte_sync <= (i == 0);
            end
            tick(2);
            stream_clock_in <= 1'b1;
            tick(2);
            if (fall)
            begin
                stream_data_in <= lsb ? b[i] : b[7 - i];
                byte_sync <= (i == 0);
            end
            tick(2);
            stream_clock_in <= 1'b0;
            tick(2);
        end
        stream_data_in <= ~stream_data_in;
        byte_sync <= 1'b0;
        tick(4);
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the audio decoder serial ports
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import afd_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, e, dec_byte_take = 1'b0;
    logic ctl_select_n, ctl_sclk, ctl_sdi, ctl_sdo, ctl_sdo_oe, stream_clock_in, stream_clock_out;
    logic stream_clock_oe, stream_data_in, byte_sync, data_request, dec_byte_valid;
    logic [7:0] dec_byte_data;
    int n_fail = 0, n_tests = 0, oe_hits = 0;
    always #10 pclk = ~pclk;
    always @(posedge pclk)
        if (ctl_sdo_oe === 1'b1)
            oe_hits <= oe_hits + 1;
    afd_serial_ports uut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ctl_select_n, .ctl_sclk, .ctl_sdi, .ctl_sdo, .ctl_sdo_oe,
        .stream_clock_in, .stream_clock_out, .stream_clock_oe, .stream_data_in, .byte_sync,
        .data_request, .dec_byte_data, .dec_byte_valid, .dec_byte_take);
    afd_host_model u_host (.pclk, .ctl_select_n, .ctl_sclk, .ctl_sdi, .ctl_sdo, .stream_clock_in,
        .stream_data_in, .byte_sync);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 20)
        begin
            n_fail++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_apb();
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("reset", 32'h0000_0000, q);
        apb(1'b1, 12'h008, 32'h1234_5678);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("rw", 32'h0000_5678, q);
        apb(1'b0, 12'h080, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, 32'(e));
        $display("apb done");
    endtask
    task automatic t_cp();
        logic [15:0] r;
        int h;
        h = oe_hits;
        u_host.cp({OPC_WRITE, 8'h05, 16'ha5c3}, r);
        chk("wr oe", 32'h0000_0000, 32'(oe_hits - h));
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk("wr reg", 32'h0000_a5c3, q);
        u_host.cp({8'h01, 8'h05, 16'h0000}, r);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk("bad op", 32'h0000_a5c3, q);
        h = oe_hits;
        u_host.cp({OPC_READ, 8'h05, 16'h5a3c}, r);
        chk("rd data", 32'h0000_a5c3, 32'(r));
        chk("rd oe", 32'h0000_0001, 32'(oe_hits != h));
        chk("oe idle", 32'h0000_0000, 32'(ctl_sdo_oe));
        $display("control port done");
    endtask
    task automatic t_byte(input logic [7:0] b, input logic lsb, input logic fall);
        int k;
        chk("data_request", 32'h0000_0001, 32'(data_request));
        u_host.st(b, lsb, fall);
        for (k = 0; k < 40 && dec_byte_valid !== 1'b1; k++)
            @(posedge pclk);
        if (k == 40)
        begin
            n_fail++;
            wrap_up();
        end
        chk("byte", 32'(b), 32'(dec_byte_data));
        dec_byte_take <= 1'b1;
        @(posedge pclk);
        dec_byte_take <= 1'b0;
    endtask
    task automatic t_stream();
        t_byte(8'hb4, 1'b0, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0200);
        t_byte(8'h6d, 1'b1, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0300);
        t_byte(8'h2e, 1'b1, 1'b1);
        $display("stream done");
    endtask
    task automatic t_master();
        int k, n;
        apb(1'b1, 12'h000, 32'h0000_0c00);
        repeat (4) @(posedge pclk);
        chk("clk oe", 32'h0000_0001, 32'(stream_clock_oe));
        chk("data_request m", 32'h0000_0000, 32'(data_request));
        for (k = 0; k < 100 && stream_clock_out !== 1'b1; k++)
            @(posedge pclk);
        if (k == 100)
        begin
            n_fail++;
            wrap_up();
        end
        for (n = 0; n < 100 && stream_clock_out === 1'b1; n++)
            @(posedge pclk);
        chk("clk half", 32'(HALF_HI_CYC), 32'(n));
        apb(1'b0, APB_STATUS_OFFSET, 32'h0000_0000);
        chk("status", 32'h0000_0004, q & 32'h0000_0007);
        $display("master done");
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_apb();
        t_cp();
        t_stream();
        t_master();
        wrap_up();
    end
endmodule
`default_nettype wire
